// ==== common/bcsp_cmp_if.sv ====
// Compare-result path between issue, compare unit and rename stage
`timescale 1ns/1ps
interface bcsp_cmp_if;
    import bcsp_pkg::*;
    // Issue side
    logic issue;
    logic [DATA_W-1:0] a;
    logic [DATA_W-1:0] b;
    logic so_in;
    logic [CRF_W-1:0] field;
    // Early equality result
    logic eq_vld;
    logic eq_val;
    logic [CRF_W-1:0] eq_field;
    // Late ordering and overflow result
    logic rest_vld;
    logic lt_val;
    logic gt_val;
    logic so_val;
    logic [CRF_W-1:0] rest_field;

    modport core (output issue, a, b, so_in, field);
    modport cmp (input issue, a, b, so_in, field,
                 output eq_vld, eq_val, eq_field,
                 output rest_vld, lt_val, gt_val, so_val, rest_field);
    modport ren (input eq_vld, eq_val, eq_field,
                 input rest_vld, lt_val, gt_val, so_val, rest_field);
endinterface

// ==== common/bcsp_pkg.sv ====
// Shared constants, types and helpers for the branch/condition-select pipe
package bcsp_pkg;
    // ------------------------------------------------------------
    // Widths and sizes
    // ------------------------------------------------------------
    localparam int unsigned DATA_W = 32;
    localparam int unsigned ADR_W = 8;
    localparam int unsigned SEL_W = 4;
    localparam int unsigned CRF_W = 3;   // Condition field number
    localparam int unsigned CRB_W = 5;   // Condition bit number
    localparam int unsigned GPR_W = 3;   // General register number
    localparam int unsigned GPR_N = 8;
    localparam int unsigned CNT_W = 8;   // Event counters
    localparam int unsigned PND_W = 2;   // Pending slot count
    localparam int unsigned OP_W = 4;
    localparam int unsigned FN_W = 3;

    // ------------------------------------------------------------
    // Register word indexes (byte address = index * 4)
    // ------------------------------------------------------------
    localparam logic [5:0] IDX_CMD = 6'h00;
    localparam logic [5:0] IDX_CTRL = 6'h01;
    localparam logic [5:0] IDX_STATUS = 6'h02;
    localparam logic [5:0] IDX_CR = 6'h03;
    localparam logic [5:0] IDX_BRANCH = 6'h04;
    localparam logic [2:0] GPR_WIN = 3'h1; // Index 0x08..0x0f

    // ------------------------------------------------------------
    // Instruction word fields (lsb positions)
    // ------------------------------------------------------------
    localparam int unsigned OP_LSB = 0;
    localparam int unsigned BI_LSB = 4;   // Tested / target bit
    localparam int unsigned CRFD_LSB = 9; // Compare target field
    localparam int unsigned BA_LSB = 12;
    localparam int unsigned BB_LSB = 17;
    localparam int unsigned RT_LSB = 22;  // Also logic function code
    localparam int unsigned RA_LSB = 25;  // first_source_field
    localparam int unsigned RB_LSB = 28;

    // Operation codes
    typedef enum logic [3:0] {
        OP_NOP = 4'h0,
        OP_CMP = 4'h1,
        OP_BC = 4'h2,
        OP_CRLOG = 4'h3,
        OP_SEL = 4'h4,
        OP_ADDC = 4'h5,
        OP_ADDE = 4'h6,
        OP_ADDO = 4'h7,
        OP_SETSO = 4'h8
    } bcsp_op_t;

    // Condition-bit logic functions
    localparam logic [2:0] FN_AND = 3'h0;
    localparam logic [2:0] FN_OR = 3'h1;
    localparam logic [2:0] FN_XOR = 3'h2;
    localparam logic [2:0] FN_NOR = 3'h3;
    localparam logic [2:0] FN_NAND = 3'h4;
    localparam logic [2:0] FN_ANDC = 3'h5;
    localparam logic [2:0] FN_EQV = 3'h6;
    localparam logic [2:0] FN_ORC = 3'h7;

    // Bit position inside one condition field
    localparam logic [1:0] POS_LT = 2'h0;
    localparam logic [1:0] POS_GT = 2'h1;
    localparam logic [1:0] POS_EQ = 2'h2;
    localparam logic [1:0] POS_SO = 2'h3;

    // ------------------------------------------------------------
    // Register layouts and reset values
    // ------------------------------------------------------------
    localparam int unsigned CTRL_RUN = 0;
    localparam logic [31:0] CTRL_RST = 32'h0000_0001;
    localparam int unsigned ST_CARRY = 0;
    localparam int unsigned ST_SO = 1;
    localparam int unsigned ST_PEND = 2;
    localparam int unsigned ST_FLUSH = 8;
    localparam int unsigned BR_SEEN = 0;
    localparam int unsigned BR_TAKEN = 1;
    localparam int unsigned BR_EARLY = 2;
    localparam int unsigned BR_CNT = 8;
    localparam logic [31:0] ZERO_W = 32'h0000_0000;
    localparam logic [2:0] GPR_ZERO = 3'h0;

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    // One-hot mask of a condition bit
    function automatic logic [31:0] bit_mask(input logic [CRF_W-1:0] f,
                                             input logic [1:0] p);
        bit_mask = 32'h0000_0001 << {f, p};
    endfunction

    // Mask of all four bits of a field
    function automatic logic [31:0] fld_mask(input logic [CRF_W-1:0] f);
        fld_mask = 32'h0000_000f << {f, 2'h0};
    endfunction

    // Condition-bit logic evaluation
    function automatic logic crlog(input logic [2:0] fn, input logic a,
                                   input logic b);
        unique case (fn)
            FN_AND: crlog = a & b;
            FN_OR: crlog = a | b;
            FN_XOR: crlog = a ^ b;
            FN_NOR: crlog = ~(a | b);
            FN_NAND: crlog = ~(a & b);
            FN_ANDC: crlog = a & ~b;
            FN_EQV: crlog = ~(a ^ b);
            FN_ORC: crlog = a | ~b;
        endcase
    endfunction

    // Byte-lane merge for a Wishbone write
    function automatic logic [31:0] lane_merge(input logic [31:0] old_w,
                                               input logic [31:0] new_w,
                                               input logic [3:0] sel);
        for (int i = 0; i < 4; i++) begin
            lane_merge[i*8 +: 8] = sel[i] ? new_w[i*8 +: 8]
                                          : old_w[i*8 +: 8];
        end
    endfunction
endpackage

// ==== src/bcsp_cmp.sv ====
// Two-stage compare unit: equality one stage ahead of the rest
`timescale 1ns/1ps
module bcsp_cmp (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Compare path
    bcsp_cmp_if.cmp cif
);
    import bcsp_pkg::*;

    // ------------------------------------------------------------
    // Stage registers
    // ------------------------------------------------------------
    logic s1_vld;               // Result stage 1 holds a compare
    logic s2_vld;               // Result stage 2 holds a compare
    logic s1_eq, s1_lt, s1_gt, s1_so;
    logic s2_lt, s2_gt, s2_so;
    logic [CRF_W-1:0] s1_field;
    logic [CRF_W-1:0] s2_field;

    // Signed comparison of the operands
    wire cmp_lt = $signed(cif.a) < $signed(cif.b);
    wire cmp_gt = $signed(cif.a) > $signed(cif.b);
    wire cmp_eq = cif.a == cif.b;

    // Valid pipe, the only control state
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s1_vld <= 1'b0;
            s2_vld <= 1'b0;
        end else begin
            s1_vld <= cif.issue;
            s2_vld <= s1_vld;
        end
    end

    // Data pipe, no reset needed
    always_ff @(posedge clk_i) begin
        s1_eq <= cmp_eq;
        s1_lt <= cmp_lt;
        s1_gt <= cmp_gt;
        s1_so <= cif.so_in;
        s1_field <= cif.field;
        s2_lt <= s1_lt;
        s2_gt <= s1_gt;
        s2_so <= s1_so;
        s2_field <= s1_field;
    end

    // Equality leaves after one stage, the rest after two
    assign cif.eq_vld = s1_vld;
    assign cif.eq_val = s1_eq;
    assign cif.eq_field = s1_field;
    assign cif.rest_vld = s2_vld;
    assign cif.lt_val = s2_lt;
    assign cif.gt_val = s2_gt;
    assign cif.so_val = s2_so;
    assign cif.rest_field = s2_field;
endmodule

// ==== src/bcsp_core.sv ====
// Top: issue slots, execute stage and Wishbone register file
//
// Decided for this implementation: the register offsets and register access over Wishbone.
`timescale 1ns/1ps
module bcsp_core (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [bcsp_pkg::ADR_W-1:0] wb_adr_i,
    input wire logic [bcsp_pkg::SEL_W-1:0] wb_sel_i,
    input wire logic [bcsp_pkg::DATA_W-1:0] wb_dat_i,
    output logic [bcsp_pkg::DATA_W-1:0] wb_dat_o,
    output logic wb_ack_o,
    // Pipeline events
    output logic flush_o,
    output logic branch_valid_o,
    output logic branch_taken_o,
    output logic branch_early_o
);
    import bcsp_pkg::*;

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    logic [DATA_W-1:0] gpr [GPR_N];     // General registers
    logic [DATA_W-1:0] slot_ins [2];    // Slot 0 is oldest
    logic [1:0] slot_vld;
    logic [DATA_W-1:0] ctrl;            // Software control word
    logic summary_overflow_flag;
    logic [CNT_W-1:0] flush_cnt;        // Flush events
    logic [CNT_W-1:0] br_cnt;           // Branches resolved
    logic br_seen, br_taken, br_early;  // Last branch outcome

    // Renamed state from the rename stage
    logic [31:0] condition_field_register;
    logic [31:0] cr_rdy;
    logic carry_flag;

    bcsp_cmp_if cif ();

    // ------------------------------------------------------------
    // Instruction decode
    // ------------------------------------------------------------
    wire [DATA_W-1:0] ins = slot_ins[0];
    wire bcsp_op_t op = bcsp_op_t'(ins[OP_LSB +: OP_W]);
    wire [CRB_W-1:0] bi = ins[BI_LSB +: CRB_W];
    wire [CRB_W-1:0] ba = ins[BA_LSB +: CRB_W];
    wire [CRB_W-1:0] bb = ins[BB_LSB +: CRB_W];
    wire [CRF_W-1:0] crfd = ins[CRFD_LSB +: CRF_W];
    wire [GPR_W-1:0] rt = ins[RT_LSB +: GPR_W];
    wire [GPR_W-1:0] first_source_field = ins[RA_LSB +: GPR_W];
    wire [GPR_W-1:0] rb = ins[RB_LSB +: GPR_W];
    wire [FN_W-1:0] fn = ins[RT_LSB +: FN_W];
    wire [DATA_W-1:0] ra_val = gpr[first_source_field];
    wire [DATA_W-1:0] rb_val = gpr[rb];

    // ------------------------------------------------------------
    // Stall and go
    // ------------------------------------------------------------
    // A compare must not reuse a field still waiting on results,
    // otherwise late bits of the older compare would mark it ready
    wire fld_free = &(cr_rdy | ~fld_mask(crfd));
    // Tested bit ready: equality arrives a cycle before the rest
    wire bi_rdy = cr_rdy[bi];
    wire log_rdy = cr_rdy[ba] & cr_rdy[bb] & cr_rdy[bi];
    wire stall = (op == OP_CMP) ? ~fld_free :
                 (op == OP_BC) ? ~bi_rdy :
                 (op == OP_SEL) ? ~bi_rdy :
                 (op == OP_CRLOG) ? ~log_rdy : 1'b0;
    wire run = ctrl[CTRL_RUN];
    wire go = run & slot_vld[0] & ~stall;
    wire is_cmp = go & (op == OP_CMP);
    wire is_bc = go & (op == OP_BC);
    wire is_log = go & (op == OP_CRLOG);
    wire is_sel = go & (op == OP_SEL);
    wire is_add = go & ((op == OP_ADDC) | (op == OP_ADDE)
                        | (op == OP_ADDO));

    // ------------------------------------------------------------
    // Execute datapath
    // ------------------------------------------------------------
    // Carry-in comes from the renamed carry, never a retire wait
    wire cin = (op == OP_ADDE) ? carry_flag : 1'b0;
    wire [DATA_W:0] sum = {1'b0, ra_val} + {1'b0, rb_val}
                          + {{DATA_W{1'b0}}, cin};
    wire ovf = (ra_val[DATA_W-1] == rb_val[DATA_W-1])
               & (sum[DATA_W-1] != ra_val[DATA_W-1]);
    wire next_so = (op == OP_ADDO) ? (summary_overflow_flag | ovf) :
                   (op == OP_SETSO) ? ins[BI_LSB] : summary_overflow_flag;
    wire so_write = go & ((op == OP_ADDO) | (op == OP_SETSO));
    wire so_change = so_write & (next_so != summary_overflow_flag);
    // Zero register in the first operand of a select reads as constant zero
    wire [DATA_W-1:0] sel_a = (first_source_field == GPR_ZERO) ? ZERO_W
                              : ra_val;
    // Pick an operand by one condition bit, no branch
    wire [DATA_W-1:0] sel_val = condition_field_register[bi] ? sel_a
                                : rb_val;
    wire log_val = crlog(fn, condition_field_register[ba],
                         condition_field_register[bb]);
    wire gpr_we = is_sel | is_add;
    wire [DATA_W-1:0] gpr_wd = is_sel ? sel_val : sum[DATA_W-1:0];

    // Compare issue
    assign cif.issue = is_cmp;
    assign cif.a = ra_val;
    assign cif.b = rb_val;
    assign cif.so_in = summary_overflow_flag;
    assign cif.field = crfd;

    // ------------------------------------------------------------
    // Wishbone decode
    // ------------------------------------------------------------
    wire wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    wire [5:0] idx = wb_adr_i[ADR_W-1:2];
    wire hit_cmd = idx == IDX_CMD;
    wire hit_ctrl = idx == IDX_CTRL;
    wire hit_stat = idx == IDX_STATUS;
    wire hit_cr = idx == IDX_CR;
    wire hit_br = idx == IDX_BRANCH;
    wire hit_gpr = idx[5:3] == GPR_WIN;
    wire [GPR_W-1:0] gidx = idx[GPR_W-1:0];
    // A command waits for a free slot and never lands during a flush
    wire slot_free = ~slot_vld[1] | go;
    wire push = wb_req & wb_we_i & hit_cmd & slot_free & ~so_change;
    wire wr_ok = wb_req & wb_we_i & ~hit_cmd;
    wire next_ack = wb_req & (~(wb_we_i & hit_cmd) | push);
    wire [PND_W-1:0] pend = {1'b0, slot_vld[0]} + {1'b0, slot_vld[1]};
    wire [31:0] stat_w = {16'h0000, flush_cnt, 4'h0, pend,
                          summary_overflow_flag, carry_flag};
    wire [31:0] br_w = {16'h0000, br_cnt, 5'h00, br_early, br_taken,
                        br_seen};
    wire [31:0] next_dat = hit_ctrl ? ctrl :
                           hit_stat ? stat_w :
                           hit_cr ? condition_field_register :
                           hit_br ? br_w :
                           hit_gpr ? gpr[gidx] : ZERO_W;

    // ------------------------------------------------------------
    // Issue slots
    // ------------------------------------------------------------
    logic [1:0] next_vld;
    logic [DATA_W-1:0] next_ins0;
    logic [DATA_W-1:0] next_ins1;

    // Shift on execute; an overflow change drops the younger slot
    always_comb begin
        next_vld = slot_vld;
        next_ins0 = slot_ins[0];
        next_ins1 = slot_ins[1];
        if (go) begin
            next_vld[0] = slot_vld[1] & ~so_change;
            next_ins0 = slot_ins[1];
            next_vld[1] = 1'b0;
        end
        if (push) begin
            if (!next_vld[0]) begin
                next_vld[0] = 1'b1;
                next_ins0 = wb_dat_i;
            end else begin
                next_vld[1] = 1'b1;
                next_ins1 = wb_dat_i;
            end
        end
    end

    // Slot registers
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            slot_vld <= 2'b00;
        end else begin
            slot_vld <= next_vld;
        end
        slot_ins[0] <= next_ins0;
        slot_ins[1] <= next_ins1;
    end

    // ------------------------------------------------------------
    // Architected flags and counters
    // ------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            summary_overflow_flag <= 1'b0;
            flush_cnt <= '0;
            flush_o <= 1'b0;
        end else begin
            if (so_write) begin
                summary_overflow_flag <= next_so;
            end
            // Restart after the changing instruction
            flush_o <= so_change;
            if (so_change) begin
                flush_cnt <= flush_cnt + 8'h01;
            end
        end
    end

    // ------------------------------------------------------------
    // Branch resolution
    // ------------------------------------------------------------
    // Outcome only: targets come from the instruction stream and no
    // return-address stack exists to predict returns
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            branch_valid_o <= 1'b0;
            branch_taken_o <= 1'b0;
            branch_early_o <= 1'b0;
            br_seen <= 1'b0;
            br_taken <= 1'b0;
            br_early <= 1'b0;
            br_cnt <= '0;
        end else begin
            branch_valid_o <= is_bc;
            if (is_bc) begin
                // Early flag marks the equality path
                branch_taken_o <= condition_field_register[bi];
                branch_early_o <= bi[1:0] == POS_EQ;
                br_seen <= 1'b1;
                br_taken <= condition_field_register[bi];
                br_early <= bi[1:0] == POS_EQ;
                br_cnt <= br_cnt + 8'h01;
            end
        end
    end

    // ------------------------------------------------------------
    // Register file and bus answer
    // ------------------------------------------------------------
    // Execute writes win over a software write to the same register
    always_ff @(posedge clk_i) begin
        if (wr_ok & hit_gpr) begin
            gpr[gidx] <= lane_merge(gpr[gidx], wb_dat_i, wb_sel_i);
        end
        if (gpr_we) begin
            gpr[rt] <= gpr_wd;
        end
    end

    // Control word and registered bus answer
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl <= CTRL_RST;
            wb_ack_o <= 1'b0;
            wb_dat_o <= ZERO_W;
        end else begin
            if (wr_ok & hit_ctrl) begin
                ctrl <= lane_merge(ctrl, wb_dat_i, wb_sel_i);
            end
            wb_ack_o <= next_ack;
            wb_dat_o <= next_dat;
        end
    end

    // ------------------------------------------------------------
    // Sub-units
    // ------------------------------------------------------------
    bcsp_cmp u_cmp (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .cif(cif.cmp)
    );

    // Condition fields and carry live in rename entries
    bcsp_ren u_ren (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .cif(cif.ren),
        .issue_i(is_cmp),
        .issue_field_i(crfd),
        .bit_we_i(is_log),
        .bit_idx_i(bi),
        .bit_val_i(log_val),
        .carry_we_i(is_add),
        .carry_val_i(sum[DATA_W]),
        .cr_o(condition_field_register),
        .ready_o(cr_rdy),
        .carry_o(carry_flag)
    );
endmodule

// ==== src/bcsp_ren.sv ====
// Renamed condition fields and carry flag with ready scoreboard
`timescale 1ns/1ps
module bcsp_ren (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Compare results
    bcsp_cmp_if.ren cif,
    // Compare issue marks a field busy
    input wire logic issue_i,
    input wire logic [bcsp_pkg::CRF_W-1:0] issue_field_i,
    // Single condition-bit write
    input wire logic bit_we_i,
    input wire logic [bcsp_pkg::CRB_W-1:0] bit_idx_i,
    input wire logic bit_val_i,
    // Carry write
    input wire logic carry_we_i,
    input wire logic carry_val_i,
    // Renamed state, condition bits and ready with bypass, carry without
    output logic [31:0] cr_o,
    output logic [31:0] ready_o,
    output logic carry_o
);
    import bcsp_pkg::*;

    // ------------------------------------------------------------
    // Rename entries
    // ------------------------------------------------------------
    logic [31:0] cr;            // Speculative condition fields
    logic [31:0] rdy;           // Per-bit ready
    logic carry;                // Renamed carry_flag

    // Masks of arriving results and of a freshly issued compare
    wire [31:0] eq_m = bit_mask(cif.eq_field, POS_EQ);
    wire [31:0] rest_m = fld_mask(cif.rest_field) & ~bit_mask(cif.rest_field,
                                                              POS_EQ);
    wire [31:0] eq_on = cif.eq_vld ? eq_m : ZERO_W;
    wire [31:0] rest_on = cif.rest_vld ? rest_m : ZERO_W;
    wire [31:0] iss_m = issue_i ? fld_mask(issue_field_i) : ZERO_W;
    wire [31:0] wr_m = bit_we_i ? bit_mask(bit_idx_i[CRB_W-1:2],
                                           bit_idx_i[1:0]) : ZERO_W;
    wire [31:0] rest_v = {8{cif.so_val, 1'b0, cif.gt_val, cif.lt_val}};
    wire [31:0] eq_v = {8{1'b0, cif.eq_val, 2'b00}};  // Eq sits at bit 2

    // Bypass arriving compare bits so consumers go the same cycle
    wire [31:0] byp_cr = (cr & ~eq_on & ~rest_on) | (eq_v & eq_on)
                         | (rest_v & rest_on);
    wire [31:0] byp_rdy = rdy | eq_on | rest_on;

    // Only the addressed bit changes on a logic write
    wire [31:0] next_cr = (byp_cr & ~wr_m) | ({32{bit_val_i}} & wr_m);
    wire [31:0] next_rdy = (byp_rdy | wr_m) & ~iss_m;

    assign cr_o = byp_cr;
    assign ready_o = byp_rdy;
    assign carry_o = carry;     // Read straight from the entry

    // Rename state update, every field independent
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cr <= ZERO_W;
            rdy <= ~ZERO_W;
            carry <= 1'b0;
        end else begin
            cr <= next_cr;
            rdy <= next_rdy;
            if (carry_we_i) begin
                carry <= carry_val_i;   // Visible next cycle
            end
        end
    end
endmodule

// ==== verification/bcsp_core_bench.sv ====
// Register-level bench for the branch/condition-select pipe
`timescale 1ns/1ps
module bcsp_core_bench;
    import bcsp_pkg::*;
    // ------------
    // Signals
    // ------------
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic wb_cyc_i = 1'b0;
    logic wb_stb_i = 1'b0;
    logic wb_we_i = 1'b0;
    logic [7:0] wb_adr_i = 8'h00;
    logic [31:0] wb_dat_i = 32'h0;
    logic [31:0] wb_dat_o;
    logic wb_ack_o, flush_o, branch_valid_o, branch_taken_o, branch_early_o;
    int num_errors = 0;
    int check_count = 0;
    int n_fl = 0;   // Flush pulses seen
    int n_br = 0;   // Branch pulses seen
    // General register preload
    localparam logic [31:0] GV [8] = '{32'h0, 32'h5, 32'h5, 32'h9, 32'hff,
        32'h0, 32'hffff_ffff, 32'h1};
    always #25 clk_i = ~clk_i;
    bcsp_core i_dut (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i,
        .wb_adr_i, .wb_sel_i(4'hf), .wb_dat_i, .wb_dat_o, .wb_ack_o,
        .flush_o, .branch_valid_o, .branch_taken_o, .branch_early_o);
    // Count output pulses at the edge that samples them
    always @(posedge clk_i) begin
        n_fl += int'(flush_o === 1'b1);
        n_br += int'(branch_valid_o === 1'b1);
    end
    function automatic logic [7:0] ga(input int n);
        return {GPR_WIN, n[2:0], 2'h0};
    endfunction
    // Command word from its fields
    function automatic logic [31:0] enc(input bcsp_op_t op,
        input int bi, crf, ba, bb, rt, ra, rb);
        return 32'(op) | 32'(bi << BI_LSB | crf << CRFD_LSB | ba << BA_LSB
            | bb << BB_LSB | rt << RT_LSB | ra << RA_LSB | rb << RB_LSB);
    endfunction
    // Classic cycle, held until ack is sampled; commands may back-pressure
    task automatic wb(input logic w, input logic [7:0] a,
        input logic [31:0] d, output logic [31:0] q);
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= w;
        wb_adr_i <= a;
        wb_dat_i <= d;
        do @(posedge clk_i); while (wb_ack_o !== 1'b1);
        q = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask
    task automatic rc(input string nm, input logic [7:0] a,
        input logic [31:0] e);
        logic [31:0] q;
        wb(1'b0, a, 32'h0, q);
        ck(nm, e, q);
    endtask
    // One comparison of an expected and a seen value
    task automatic ck(input string nm, input logic [31:0] e,
        input logic [31:0] s);
        check_count++;
        if (s !== e) begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        wb(1'b1, a, d, q);
    endtask
    // Poll until both issue slots are empty
    task automatic drain;
        logic [31:0] v;
        v = 32'h4;
        for (int i = 0; i < 50 && v[3:2] != 2'h0; i++)
            wb(1'b0, {IDX_STATUS, 2'h0}, 32'h0, v);
    endtask
    task automatic print_verdict;
        if (num_errors == 0 && check_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    // Hang guard, far beyond the few hundred cycles needed
    initial begin
        #2000000;
        num_errors++;
        print_verdict;
    end
    initial begin
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        rc("ctrl", {IDX_CTRL, 2'h0}, CTRL_RST);
        rc("cr", {IDX_CR, 2'h0}, ZERO_W);
        rc("hole", 8'h14, ZERO_W);
        for (int i = 1; i < 8; i++)
            wr(ga(i), GV[i]);
        wr(8'h0, enc(OP_CMP, 0, 0, 0, 0, 0, 1, 2));
        wr(8'h0, enc(OP_BC, 2, 0, 0, 0, 0, 0, 0));
        drain;
        rc("br eq", {IDX_BRANCH, 2'h0}, 32'h107);
        ck("out eq", 32'h3, 32'({branch_taken_o, branch_early_o}));
        wr(8'h0, enc(OP_CMP, 0, 1, 0, 0, 0, 1, 3));
        wr(8'h0, enc(OP_BC, 4, 0, 0, 0, 0, 0, 0));
        wr(8'h0, enc(OP_CRLOG, 8, 0, 2, 4, FN_OR, 0, 0));
        wr(8'h0, enc(OP_CRLOG, 9, 0, 2, 4, FN_ANDC, 0, 0));
        wr(8'h0, enc(OP_CMP, 0, 3, 0, 0, 0, 3, 1));
        wr(8'h0, enc(OP_SEL, 13, 0, 0, 0, 5, 3, 1));
        wr(8'h0, enc(OP_SEL, 2, 0, 0, 0, 4, 0, 1));
        wr(8'h0, enc(OP_ADDC, 0, 0, 0, 0, 0, 6, 7));
        wr(8'h0, enc(OP_ADDE, 0, 0, 0, 0, 0, 7, 7));
        drain;
        rc("br lt", {IDX_BRANCH, 2'h0}, 32'h203);
        ck("out lt", 32'h2, 32'({branch_taken_o, branch_early_o}));
        rc("cr", {IDX_CR, 2'h0}, 32'h2114);
        rc("sel", ga(5), 32'h9);
        rc("sel0", ga(4), ZERO_W);
        rc("adde", ga(0), 32'h3);
        wr(8'h0, enc(OP_SETSO, 1, 0, 0, 0, 0, 0, 0));
        drain;
        rc("status", {IDX_STATUS, 2'h0}, 32'h102);
        // Halted core holds an overflow change with a younger add behind
        wr({IDX_CTRL, 2'h0}, ZERO_W);
        wr(8'h0, enc(OP_SETSO, 0, 0, 0, 0, 0, 0, 0));
        wr(8'h0, enc(OP_ADDC, 0, 0, 0, 0, 1, 6, 7));
        wr({IDX_CTRL, 2'h0}, CTRL_RST);
        drain;
        rc("dropped", ga(1), 32'h5);
        rc("status2", {IDX_STATUS, 2'h0}, 32'h200);
        ck("flushes", 32'h2, 32'(n_fl));
        ck("branches", 32'h2, 32'(n_br));
        print_verdict;
    end
endmodule

// ==== verification/bcsp_props.sv ====
// Port-level checker for the branch/condition-select pipe
`timescale 1ns/1ps
module bcsp_props (
    // Clock, reset and bus
    input wire logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o,
    input wire logic [bcsp_pkg::ADR_W-1:0] wb_adr_i,
    input wire logic [bcsp_pkg::DATA_W-1:0] wb_dat_o,
    // Pipeline events
    input wire logic flush_o, branch_valid_o, branch_taken_o, branch_early_o
);
    import bcsp_pkg::*;
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // ------------
    // Decode
    // ------------
    wire [5:0] idx = wb_adr_i[7:2];
    // Command word reads as zero, like holes in the map
    wire unmapped = idx == IDX_CMD || (idx > IDX_BRANCH && idx < 6'h08)
        || idx > 6'h0f;
    AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack wider than one cycle");
    AST_ACK_CAUSE: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
        else $error("ack without request");
    AST_UNMAP_ZERO: assert property (wb_ack_o && !$past(wb_we_i)
        && $past(unmapped) |-> wb_dat_o == ZERO_W)
        else $error("unmapped read not zero");
    AST_FLUSH_PULSE: assert property (flush_o |=> !flush_o)
        else $error("flush wider than one cycle");
    // A command must never land in the slot being flushed
    AST_FLUSH_NO_CMD: assert property (flush_o && wb_ack_o |->
        !($past(wb_we_i) && $past(idx) == IDX_CMD))
        else $error("command taken on overflow change");
    AST_BR_PULSE: assert property (branch_valid_o |=>
        !branch_valid_o) else $error("branch valid wider than one cycle");
    AST_TAKEN_HOLD: assert property (!branch_valid_o |->
        $stable(branch_taken_o)) else $error("taken moved");
    AST_EARLY_HOLD: assert property (!branch_valid_o |->
        $stable(branch_early_o)) else $error("early moved");
    // Main scenarios
    cover property (branch_valid_o && branch_early_o);
    cover property (branch_valid_o && !branch_early_o);
    cover property (flush_o);
endmodule
bind bcsp_core bcsp_props i_props (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i,
    .wb_we_i, .wb_ack_o, .wb_adr_i, .wb_dat_o, .flush_o, .branch_valid_o,
    .branch_taken_o, .branch_early_o);
